// ---- rtl/sao_pkg.sv ----
package sao_pkg;

    // Axis count and connector width
    localparam int AXES = 4;
    localparam int AXIS_W = 2;
    localparam int PINS = 6;
    localparam int FUNC_W = 3;

    // Clock and power-up settle time
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned POWERUP_TIME_MS = 1500;
    localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_MS * (CLK_HZ / 1000);

    // Register byte offsets
    localparam logic [7:0] OFS_INPOS_RANGE = 8'h00;
    localparam logic [7:0] OFS_PIN_MAP0 = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2c;
    localparam logic [7:0] OFS_PIN_STATE = 8'h30;

    // Pin map field layout
    localparam int MAP_AXIS_LSB = 0;
    localparam int MAP_FUNC_LSB = 2;

    // Function codes for a connector pin
    localparam logic [FUNC_W-1:0] FN_NONE = 3'h0;
    localparam logic [FUNC_W-1:0] FN_TROUBLE = 3'h1;
    localparam logic [FUNC_W-1:0] FN_WARNING = 3'h2;
    localparam logic [FUNC_W-1:0] FN_INPOS = 3'h3;
    localparam logic [FUNC_W-1:0] FN_HOME = 3'h4;

    // Reset values
    localparam logic [31:0] INPOS_RANGE_RST = 32'h0000_0064;
    localparam logic [4:0] PIN_MAP_RST = 5'h00;
    localparam logic [2*AXES-1:0] IRQ_EN_RST = 8'h00;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PH_WAIT = 2'b01,
        PH_RUN = 2'b10
    } sao_phase_type;

    // Per-axis condition inputs from the servo core
    typedef struct packed {
        logic alarm;
        logic warning;
        logic base_off;
        logic servo_on;
        logic home_finish;
        logic ready;
        logic home_clear;
        logic signed [31:0] droop;
    } sao_axis_in_type;

    // Per-axis status flags
    typedef struct packed {
        logic home;
        logic inpos;
        logic warning;
        logic trouble;
    } sao_flags_type;

    typedef struct packed {
        sao_phase_type phase;
        logic [31:0] pwr_cnt;
        sao_flags_type [AXES-1:0] flags;
        logic [PINS-1:0] pins;
        logic [31:0] inpos_range;
        logic [PINS-1:0][4:0] pin_map;
        logic [2*AXES-1:0] irq_status;
        logic [2*AXES-1:0] irq_enable;
        logic irq;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sao_state_type;

endpackage

// ---- rtl/sao_status_outputs.sv ----
// Contract
// [RULE_01] Pin-to-flag mapping set by six map registers
// [RULE_02] Pin-routed flags also shown in fieldbus image
// [RULE_03] Every flag exists once per axis
// [RULE_04] Trouble off on power loss or trip
// [RULE_05] Trouble on within settle delay without alarm
// [RULE_06] Warning on while warning condition active
// [RULE_07] Warning off after power-on when none
// [RULE_08] In-position on when droop within range
// [RULE_09] In-position range from dedicated register
// [RULE_10] In-position needs servo-on, off during shutoff
// [RULE_11] Home flag set on finish, cleared on conditions
// [RULE_12] Flags registered, held off during reset
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module sao_status_outputs #(
    parameter int unsigned POWERUP_CYCLES = sao_pkg::POWERUP_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic power_ok_in,
    input sao_pkg::sao_axis_in_type [sao_pkg::AXES-1:0] axis_cond_in,
    output logic [sao_pkg::PINS-1:0] status_output_connector_out,
    output sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] fieldbus_image_out,
    output logic irq_out,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out
);

    sao_pkg::sao_state_type st_q;
    sao_pkg::sao_state_type st_d;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Index of a pin map register, or PINS when the offset is not one
    function automatic int pin_index(input logic [7:0] addr);
        int idx;
        idx = sao_pkg::PINS;
        for (int p = 0; p < sao_pkg::PINS; p++) begin
            if (addr == sao_pkg::OFS_PIN_MAP0 + 8'(4 * p)) begin
                idx = p;
            end
        end
        return idx;
    endfunction

    // Magnitude of a signed droop count
    function automatic logic [31:0] droop_mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    // Flag picked by one pin map entry
    function automatic logic pick_flag(input logic [4:0] map,
                                       input sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] fl);
        logic [sao_pkg::AXIS_W-1:0] ax;
        logic [sao_pkg::FUNC_W-1:0] fn;
        logic res;
        ax = map[sao_pkg::MAP_AXIS_LSB +: sao_pkg::AXIS_W];
        fn = map[sao_pkg::MAP_FUNC_LSB +: sao_pkg::FUNC_W];
        unique case (fn)
            sao_pkg::FN_TROUBLE: res = fl[ax].trouble;
            sao_pkg::FN_WARNING: res = fl[ax].warning;
            sao_pkg::FN_INPOS: res = fl[ax].inpos;
            sao_pkg::FN_HOME: res = fl[ax].home;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // Register read decode
    function automatic logic [32:0] read_word(input logic [7:0] addr,
                                              input sao_pkg::sao_state_type s);
        logic [32:0] res;
        int idx;
        res = {1'b0, 32'h0000_0000};
        idx = pin_index(addr);
        if (idx < sao_pkg::PINS) begin
            res[4:0] = s.pin_map[idx];
        end else begin
            unique case (addr)
                sao_pkg::OFS_INPOS_RANGE: res[31:0] = s.inpos_range;
                sao_pkg::OFS_STATUS: res[4*sao_pkg::AXES-1:0] = s.flags;
                sao_pkg::OFS_IRQ_STATUS: res[2*sao_pkg::AXES-1:0] = s.irq_status;
                sao_pkg::OFS_IRQ_CLEAR: res[31:0] = 32'h0000_0000;
                sao_pkg::OFS_IRQ_ENABLE: res[2*sao_pkg::AXES-1:0] = s.irq_enable;
                sao_pkg::OFS_PIN_STATE: res[sao_pkg::PINS-1:0] = s.pins;
                default: res[32] = 1'b1;
            endcase
        end
        return res;
    endfunction

    // Handshake readies follow the holding state
    assign s_axi_awready_out = !st_q.aw_hold && !st_q.bvalid;
    assign s_axi_wready_out = !st_q.w_hold && !st_q.bvalid;
    assign s_axi_arready_out = !st_q.rvalid;
    assign s_axi_bvalid_out = st_q.bvalid;
    assign s_axi_bresp_out = st_q.bresp;
    assign s_axi_rvalid_out = st_q.rvalid;
    assign s_axi_rdata_out = st_q.rdata;
    assign s_axi_rresp_out = st_q.rresp;
    assign status_output_connector_out = st_q.pins;
    assign fieldbus_image_out = st_q.flags; // [RULE_02]
    assign irq_out = st_q.irq;

    // Next-state logic for the whole block
    always_comb begin
        logic [2*sao_pkg::AXES-1:0] ev;
        logic [2*sao_pkg::AXES-1:0] clr;
        logic [32:0] rd;
        logic [31:0] mw;
        logic do_wr;
        logic wr_hit;
        int widx;
        st_d = st_q;
        ev = '0;
        clr = '0;
        rd = '0;
        mw = '0;
        do_wr = 1'b0;
        wr_hit = 1'b0;
        widx = sao_pkg::PINS;

        // Power-up settle timer; restarts whenever power drops
        if (!power_ok_in) begin
            st_d.phase = sao_pkg::PH_WAIT;
            st_d.pwr_cnt = 32'h0000_0000;
        end else begin
            unique case (st_q.phase)
                sao_pkg::PH_WAIT: begin
                    st_d.pwr_cnt = st_q.pwr_cnt + 32'h0000_0001;
                    if (st_q.pwr_cnt >= 32'(POWERUP_CYCLES - 1)) begin // [RULE_05]
                        st_d.phase = sao_pkg::PH_RUN;
                    end
                end
                sao_pkg::PH_RUN: begin
                    st_d.pwr_cnt = st_q.pwr_cnt;
                end
                default: begin
                    st_d.phase = sao_pkg::PH_WAIT;
                end
            endcase
        end

        // Per-axis flags
        for (int a = 0; a < sao_pkg::AXES; a++) begin // [RULE_03]
            // Alarm stands for the protective trip that cuts base drive
            st_d.flags[a].trouble = power_ok_in && (st_q.phase == sao_pkg::PH_RUN)
                                    && !axis_cond_in[a].alarm; // [RULE_04] [RULE_05]
            // Warning is off from reset and follows the condition once powered
            st_d.flags[a].warning = power_ok_in && axis_cond_in[a].warning; // [RULE_06] [RULE_07]
            // Inclusive compare against the range register
            st_d.flags[a].inpos = power_ok_in && axis_cond_in[a].servo_on
                                  && !axis_cond_in[a].base_off
                                  && (droop_mag(axis_cond_in[a].droop)
                                      <= st_q.inpos_range); // [RULE_08] [RULE_09] [RULE_10]
            // Clearing wins so a stale completion cannot survive an alarm
            if (!power_ok_in || axis_cond_in[a].alarm || axis_cond_in[a].home_clear) begin
                st_d.flags[a].home = 1'b0; // [RULE_11]
            end else if (axis_cond_in[a].home_finish && axis_cond_in[a].ready) begin
                st_d.flags[a].home = 1'b1; // [RULE_11]
            end
            // Events: trouble dropping, warning rising
            ev[a] = st_q.flags[a].trouble && !st_d.flags[a].trouble;
            ev[sao_pkg::AXES + a] = !st_q.flags[a].warning && st_d.flags[a].warning;
        end

        // Connector pins follow the registered flags
        for (int p = 0; p < sao_pkg::PINS; p++) begin
            st_d.pins[p] = pick_flag(st_q.pin_map[p], st_q.flags); // [RULE_01]
        end

        // Write channel: address and data taken in either order
        if (s_axi_awvalid_in && !st_q.aw_hold && !st_q.bvalid) begin
            st_d.aw_hold = 1'b1;
            st_d.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !st_q.w_hold && !st_q.bvalid) begin
            st_d.w_hold = 1'b1;
            st_d.w_data = s_axi_wdata_in;
            st_d.w_strb = s_axi_wstrb_in;
        end
        if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
            do_wr = 1'b1;
            st_d.aw_hold = 1'b0;
            st_d.w_hold = 1'b0;
            st_d.bvalid = 1'b1;
        end else if (st_q.bvalid && s_axi_bready_in) begin
            st_d.bvalid = 1'b0;
        end

        // Register writes
        if (do_wr) begin
            widx = pin_index(st_q.aw_addr);
            wr_hit = 1'b1;
            if (widx < sao_pkg::PINS) begin
                // Whole word merged by byte lanes; only the 5-bit map field is stored
                mw = merge_bytes({27'h0, st_q.pin_map[widx]}, st_q.w_data, st_q.w_strb);
                st_d.pin_map[widx] = mw[4:0]; // [RULE_01]
            end else begin
                unique case (st_q.aw_addr)
                    sao_pkg::OFS_INPOS_RANGE: begin
                        st_d.inpos_range = merge_bytes(st_q.inpos_range, st_q.w_data,
                                                       st_q.w_strb); // [RULE_09]
                    end
                    sao_pkg::OFS_IRQ_CLEAR: begin
                        mw = merge_bytes(32'h0, st_q.w_data, st_q.w_strb);
                        clr = mw[2*sao_pkg::AXES-1:0];
                    end
                    sao_pkg::OFS_IRQ_ENABLE: begin
                        mw = merge_bytes({24'h0, st_q.irq_enable}, st_q.w_data, st_q.w_strb);
                        st_d.irq_enable = mw[2*sao_pkg::AXES-1:0];
                    end
                    sao_pkg::OFS_STATUS, sao_pkg::OFS_IRQ_STATUS, sao_pkg::OFS_PIN_STATE: begin
                        wr_hit = 1'b1;
                    end
                    default: begin
                        wr_hit = 1'b0;
                    end
                endcase
            end
            st_d.bresp = wr_hit ? sao_pkg::RESP_OKAY : sao_pkg::RESP_SLVERR;
        end

        // Sticky status: a new event beats a clear in the same cycle
        st_d.irq_status = (st_q.irq_status & ~clr) | ev;
        st_d.irq = |(st_d.irq_status & st_d.irq_enable);

        // Read channel: one-cycle answer
        if (s_axi_arvalid_in && !st_q.rvalid) begin
            rd = read_word(s_axi_araddr_in, st_q);
            st_d.rvalid = 1'b1;
            st_d.rdata = rd[31:0];
            st_d.rresp = rd[32] ? sao_pkg::RESP_SLVERR : sao_pkg::RESP_OKAY;
        end else if (st_q.rvalid && s_axi_rready_in) begin
            st_d.rvalid = 1'b0;
        end
    end

    // State register; all flags and pins held off in reset
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q <= '0; // [RULE_12]
            st_q.phase <= sao_pkg::PH_WAIT;
            st_q.inpos_range <= sao_pkg::INPOS_RANGE_RST;
            st_q.irq_enable <= sao_pkg::IRQ_EN_RST;
            for (int p = 0; p < sao_pkg::PINS; p++) begin
                st_q.pin_map[p] <= sao_pkg::PIN_MAP_RST;
            end
        end else begin
            st_q <= st_d; // [RULE_12]
        end
    end

endmodule

// ---- sim/sao_checker.sv ----
`timescale 1ns/1ps
module sao_checker #(
    parameter int unsigned POWERUP_CYCLES = 20
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic power_ok_in,
    input sao_pkg::sao_axis_in_type [sao_pkg::AXES-1:0] axis_cond_in,
    input wire logic [sao_pkg::PINS-1:0] status_output_connector_out,
    input sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] fieldbus_image_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Powered cycles; saturates so a long run never wraps
    logic [31:0] pwr_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !power_ok_in)
            pwr_q <= 32'h0;
        else if (pwr_q != 32'hffff_ffff)
            pwr_q <= pwr_q + 32'h1;
    end
    // Per-axis flag relations, one edge from cause
    for (genvar a = 0; a < sao_pkg::AXES; a++) begin : g_ax
        warn_follow_a:
            assert property (1'b1 |=> fieldbus_image_out[a].warning ==
                ($past(power_ok_in) && $past(axis_cond_in[a].warning)))
                else $error("warning flag");
        trouble_off_a:
            assert property (!power_ok_in || axis_cond_in[a].alarm |=>
                !fieldbus_image_out[a].trouble) else $error("trouble not cleared");
        // Margin of two cycles covers where the settle count starts
        trouble_on_a:
            assert property (power_ok_in && pwr_q > POWERUP_CYCLES + 1 &&
                !axis_cond_in[a].alarm |=> fieldbus_image_out[a].trouble)
                else $error("trouble not set");
        inpos_off_a:
            assert property (axis_cond_in[a].base_off || !axis_cond_in[a].servo_on |=>
                !fieldbus_image_out[a].inpos) else $error("inpos during shutoff");
        home_clear_a:
            assert property (axis_cond_in[a].home_clear || axis_cond_in[a].alarm ||
                !power_ok_in |=> !fieldbus_image_out[a].home) else $error("home kept");
        home_set_a:
            assert property (axis_cond_in[a].home_finish && axis_cond_in[a].ready &&
                !axis_cond_in[a].home_clear && !axis_cond_in[a].alarm && power_ok_in
                |=> fieldbus_image_out[a].home) else $error("home not set");
    end
    pins_idle_a:
        assert property (fieldbus_image_out == '0 |=> status_output_connector_out == '0)
            else $error("pin without flag");
    flags_reset_a:
        assert property (disable iff (1'b0) !rst_n_in |=> fieldbus_image_out == '0 &&
            status_output_connector_out == '0) else $error("flags in reset");
    resp_drop_a:
        assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
            else $error("write response repeated");
endmodule

bind sao_status_outputs sao_checker #(
    .POWERUP_CYCLES(POWERUP_CYCLES)
) i_chk (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .power_ok_in(power_ok_in),
    .axis_cond_in(axis_cond_in),
    .status_output_connector_out(status_output_connector_out),
    .fieldbus_image_out(fieldbus_image_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in)
);

// ---- sim/sao_plc_model.sv ----
`timescale 1ns/1ps
module sao_plc_model (
    input wire logic clk_in,
    input wire logic [sao_pkg::PINS-1:0] pins_in,
    input sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] image_in,
    output logic [sao_pkg::PINS-1:0] pins_seen_out,
    output sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] image_seen_out
);
    // Controller scan: one snapshot a clock, so it lags the block by one edge
    always_ff @(posedge clk_in) begin
        pins_seen_out <= pins_in;
        image_seen_out <= image_in;
    end
endmodule

// ---- sim/sao_status_outputs_tb_top.sv ----
`timescale 1ns/1ps
module sao_status_outputs_tb_top;
    localparam int unsigned PWR = 20;
    localparam logic [31:0] DROOP [5] = '{32'h0a, 32'hffff_fff6, 32'h0b, 32'h0a, 32'h0a};
    localparam logic [4:0] SRV = 5'h0f;
    localparam logic [4:0] BASE = 5'h08;
    localparam logic [4:0] EXP = 5'h03;
    logic core_clk_in, rst_n_in, power_ok_in, irq;
    logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0] bresp, rresp;
    logic [sao_pkg::PINS-1:0] pins, pins_seen;
    sao_pkg::sao_axis_in_type [sao_pkg::AXES-1:0] cond;
    sao_pkg::sao_flags_type [sao_pkg::AXES-1:0] image, image_seen;
    int fail_count, comparisons;

    sao_status_outputs #(
        .POWERUP_CYCLES(PWR)
    ) i_dut (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .power_ok_in(power_ok_in),
        .axis_cond_in(cond),
        .status_output_connector_out(pins),
        .fieldbus_image_out(image),
        .irq_out(irq),
        .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_rdy),
        .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hf),
        .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br),
        .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rr),
        .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp)
    );
    sao_plc_model i_plc (
        .clk_in(core_clk_in),
        .pins_in(pins),
        .image_in(image),
        .pins_seen_out(pins_seen),
        .image_seen_out(image_seen)
    );
    // Clock
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge core_clk_in);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
            ad = ad | awr;
            dd = dd | wr_rdy;
        end
        while (bv !== 1'b1) @(posedge core_clk_in);
        chk("bresp", {30'h0, bresp}, {30'h0, r});
        br <= 1'b0;
        // One idle edge so a following call never re-drives bready in this step
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge core_clk_in); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge core_clk_in); while (rv !== 1'b1);
        chk("rdata", rdat, d);
        chk("rresp", {30'h0, rresp}, {30'h0, r});
        rr <= 1'b0;
        @(posedge core_clk_in);
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end
    initial begin
        rst_n_in <= 1'b0;
        power_ok_in <= 1'b1;
        cond <= '0;
        {awv, wv, br, arv, rr, awa, ara, wd} <= '0;
        tick(3);
        rst_n_in <= 1'b1;
        tick(1);
        chk("reset image", {16'h0, image_seen}, 32'h0);
        rd(sao_pkg::OFS_INPOS_RANGE, sao_pkg::INPOS_RANGE_RST, sao_pkg::RESP_OKAY);
        rd(sao_pkg::OFS_PIN_MAP0, 32'h0, sao_pkg::RESP_OKAY);
        rd(sao_pkg::OFS_IRQ_ENABLE, 32'h0, sao_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, sao_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0, sao_pkg::RESP_SLVERR);
        tick(PWR + 4);
        chk("settled", {16'h0, image_seen}, 32'h1111);
        // One axis at a time, so a crossed index shows up
        for (int a = 0; a < sao_pkg::AXES; a++) begin
            cond[a].warning <= 1'b1;
            tick(3);
            chk("warning", {16'h0, image_seen}, 32'h1111 | (32'h2 << (4 * a)));
            cond[a].warning <= 1'b0;
        end
        wr(sao_pkg::OFS_IRQ_ENABLE, 32'hff, sao_pkg::RESP_OKAY);
        tick(2);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(sao_pkg::OFS_IRQ_STATUS, 32'hf0, sao_pkg::RESP_OKAY);
        wr(sao_pkg::OFS_IRQ_CLEAR, 32'hf0, sao_pkg::RESP_OKAY);
        rd(sao_pkg::OFS_IRQ_STATUS, 32'h0, sao_pkg::RESP_OKAY);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(sao_pkg::OFS_IRQ_CLEAR, 32'h0, sao_pkg::RESP_OKAY);
        // Masked warning event, then enabled trouble event on axis 2
        wr(sao_pkg::OFS_IRQ_ENABLE, 32'h0f, sao_pkg::RESP_OKAY);
        cond[0].warning <= 1'b1;
        tick(3);
        chk("irq masked", {31'h0, irq}, 32'h0);
        cond[2].alarm <= 1'b1;
        tick(3);
        chk("trip", {16'h0, image_seen}, 32'h1013);
        chk("irq trip", {31'h0, irq}, 32'h1);
        rd(sao_pkg::OFS_IRQ_STATUS, 32'h14, sao_pkg::RESP_OKAY);
        cond[0].warning <= 1'b0;
        cond[2].alarm <= 1'b0;
        power_ok_in <= 1'b0;
        tick(3);
        chk("power off", {16'h0, image_seen}, 32'h0);
        power_ok_in <= 1'b1;
        tick(PWR + 4);
        chk("power back", {16'h0, image_seen}, 32'h1111);
        wr(sao_pkg::OFS_IRQ_CLEAR, 32'hff, sao_pkg::RESP_OKAY);
        // In-position window: inclusive, both signs, gated by servo state
        wr(sao_pkg::OFS_INPOS_RANGE, 32'h0a, sao_pkg::RESP_OKAY);
        for (int a = 0; a < 5; a++) begin
            cond[1].droop <= DROOP[a];
            cond[1].servo_on <= SRV[a];
            cond[1].base_off <= BASE[a];
            tick(3);
            chk("inpos", {31'h0, image_seen[1].inpos}, {31'h0, EXP[a]});
        end
        cond[1].servo_on <= 1'b1;
        cond[1].home_finish <= 1'b1;
        cond[1].ready <= 1'b1;
        tick(1);
        cond[1].home_finish <= 1'b0;
        // Pins 0..4 take every function code on axis 1
        for (int a = 0; a < 5; a++)
            wr(sao_pkg::OFS_PIN_MAP0 + 8'(4 * a), 32'((a << 2) | 1), sao_pkg::RESP_OKAY);
        tick(3);
        chk("pins", {26'h0, pins_seen}, 32'h1a);
        chk("image axis 1", {28'h0, image_seen[1]}, 32'hd);
        rd(sao_pkg::OFS_PIN_STATE, 32'h1a, sao_pkg::RESP_OKAY);
        cond[1].home_clear <= 1'b1;
        tick(1);
        cond[1].home_clear <= 1'b0;
        tick(3);
        chk("home cleared", {26'h0, pins_seen}, 32'h0a);
        complete_run();
    end
endmodule
